// file: rtl/fsr_pkg.sv
// Constants, states and command codes for the secure region command state machine.
// Assumes one 25 MHz clock and a synchronous active-high reset shared by both ends.
package fsr_pkg;
   // ****************************************
   // Widths.
   // ****************************************
   localparam int FSR_AW = 12; // Command address width.
   localparam int FSR_DW = 16; // Data width.
   localparam int FSR_SW = 8; // Sector address width.
   // ****************************************
   // Command addresses and data.
   // ****************************************
   localparam logic [11:0] FSR_ADDR_UNLOCK1 = 12'h555; // First unlock and command address.
   localparam logic [11:0] FSR_ADDR_UNLOCK2 = 12'h2aa; // Second unlock address.
   localparam logic [7:0] FSR_CMD_RESET = 8'hf0; // Software reset or overlay exit.
   localparam logic [7:0] FSR_CMD_SR_READ = 8'h70; // Status read entry.
   localparam logic [7:0] FSR_CMD_SR_CLEAR = 8'h71; // Status clear.
   localparam logic [7:0] FSR_CMD_UNLOCK1 = 8'haa; // First unlock data.
   localparam logic [7:0] FSR_CMD_UNLOCK2 = 8'h55; // Second unlock data.
   localparam logic [7:0] FSR_CMD_WORD_PGM = 8'ha0; // Word program entry.
   localparam logic [7:0] FSR_CMD_BUF_LOAD = 8'h25; // Buffer load.
   localparam logic [7:0] FSR_CMD_EXIT_ENTRY = 8'h90; // Command set exit entry.
   localparam logic [7:0] FSR_CMD_EXIT = 8'h00; // Command set exit.
   localparam logic [8:0] FSR_MAX_WC = 9'h100; // Largest buffer count, 256 words.
   // ****************************************
   // Timing.
   // ****************************************
   localparam int FSR_CLK_NS = 40; // Clock period.
   localparam int FSR_PGM_NS = 400; // Program time of the model array.
   localparam logic [7:0] FSR_PGM_CYC = 8'((FSR_PGM_NS + FSR_CLK_NS - 1) / FSR_CLK_NS); // Cycles.
   // ****************************************
   // Status bits.
   // ****************************************
   localparam int FSR_SR_READY = 7; // Device ready.
   localparam int FSR_SR_PGM_ERR = 4; // Program failed.
   localparam int FSR_SR_ABORT = 3; // Buffer load aborted.
   localparam logic [7:0] FSR_SR_RESET = 8'h80; // Status after reset.
   // ****************************************
   // States, Gray along read, unlock, program.
   // ****************************************
   typedef enum logic [3:0]
   {
      FSR_ARRAY_READ = 4'h0,
      FSR_SECURE_REGION_READ = 4'h1,
      FSR_SECURE_UNLOCK_FIRST = 4'h3,
      FSR_SECURE_UNLOCK_SECOND = 4'h2,
      FSR_SECURE_WORD_PROGRAM_ENTRY = 4'h6,
      FSR_SECURE_PROGRAM_BUSY = 4'h7,
      FSR_SECURE_BUFFER_LOAD = 4'h5,
      FSR_SECURE_BUFFER_DATA = 4'h4,
      FSR_SECURE_CMDSET_EXIT = 4'hc,
      FSR_SECURE_STATUS_READ = 4'hd,
      FSR_QUERY = 4'hf,
      FSR_QUERY_STATUS_READ = 4'he
   } fsr_state_type;
endpackage

// file: rtl/fsr_if.sv
// Command bus between the host and the secure region command state machine.
// Assumes both ends run on the same clock; the testbench supplies it.
`timescale 1ns/1ps
interface fsr_if
   import fsr_pkg::*;
(
   input wire logic clk_i // Shared clock.
);
   logic we; // Write cycle strobe, one cycle.
   logic re; // Read cycle strobe, one cycle.
   logic [FSR_AW-1:0] addr; // Command or word address.
   logic [FSR_SW-1:0] sector; // Sector address of the cycle.
   logic [FSR_DW-1:0] wdata; // Write data.
   logic [FSR_DW-1:0] rdata; // Read data, valid with rvalid.
   logic rvalid; // Read answer, one cycle after re.
   // ****************************************
   // Modports.
   // ****************************************
   modport device (input we, re, addr, sector, wdata, output rdata, rvalid);
   modport host (output we, re, addr, sector, wdata, input rdata, rvalid);
endinterface

// file: rtl/fsr_device.sv
// Device end: command decoder for the query and secure region overlays.
// Assumes one command cycle per strobe, synchronous to clk_i; array data is a stub.
`timescale 1ns/1ps
module fsr_device
   import fsr_pkg::*;
(
   input wire logic clk_i, // Clock.
   input wire logic rst_i, // Synchronous reset, high.
   input wire logic ce_i, // Clock enable; low freezes state.
   fsr_if.device bus, // Command bus.
   input wire logic enter_query_i, // Enter query mode, pulse.
   input wire logic enter_secure_i, // Enter secure overlay, pulse.
   input wire logic [FSR_DW-1:0] array_data_i, // Array word.
   input wire logic [FSR_DW-1:0] query_data_i, // Query word.
   input wire logic [FSR_DW-1:0] secure_data_i, // Secure region word.
   output logic pgm_start_o, // Program start pulse.
   output logic [FSR_AW-1:0] pgm_addr_o, // Program address.
   output logic [FSR_DW-1:0] pgm_data_o, // Program data.
   output logic [3:0] state_o // Present state.
);
   fsr_state_type state_r; // Present state.
   fsr_state_type ret_r; // State to resume after a status read.
   logic [7:0] status_r; // Status register.
   logic [8:0] wc_r; // Words still to load.
   logic [FSR_SW-1:0] sect_r; // Sector of the buffer load.
   logic [7:0] busy_r; // Program cycles left.
   logic [7:0] cmd; // Low byte of the write.
   logic at555, at2aa, rst_cmd; // Decode terms.
   assign cmd = bus.wdata[7:0];
   assign at555 = bus.addr == FSR_ADDR_UNLOCK1;
   assign at2aa = bus.addr == FSR_ADDR_UNLOCK2;
   assign rst_cmd = cmd == FSR_CMD_RESET;
   assign state_o = state_r;
   // ****************************************
   // Command state machine.
   // ****************************************
   // One write moves at most one step; reads never change state except the one-shot status read.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= FSR_ARRAY_READ;
         ret_r <= FSR_ARRAY_READ;
         wc_r <= 9'h000;
         sect_r <= '0;
      end
      else if (ce_i)
      begin
         if (bus.re && (state_r == FSR_QUERY_STATUS_READ || state_r == FSR_SECURE_STATUS_READ))
         begin
            state_r <= ret_r;
         end
         else if (state_r == FSR_SECURE_PROGRAM_BUSY && busy_r == 8'h01 && !bus.we)
         begin
            state_r <= FSR_SECURE_PROGRAM_BUSY; // Completion only sets ready.
         end
         else if (bus.we)
         begin
            case (state_r)
               FSR_ARRAY_READ:
               begin
                  // Overlay entry sequences live in the main machine outside.
                  state_r <= FSR_ARRAY_READ;
               end
               FSR_QUERY:
               begin
                  if (rst_cmd)
                     state_r <= FSR_ARRAY_READ;
                  else if (at555 && cmd == FSR_CMD_SR_READ)
                  begin
                     ret_r <= FSR_QUERY;
                     state_r <= FSR_QUERY_STATUS_READ;
                  end
               end
               FSR_SECURE_REGION_READ:
               begin
                  if (rst_cmd)
                     state_r <= FSR_ARRAY_READ;
                  else if (at555 && cmd == FSR_CMD_SR_READ)
                  begin
                     ret_r <= FSR_SECURE_REGION_READ;
                     state_r <= FSR_SECURE_STATUS_READ;
                  end
                  else if (at555 && cmd == FSR_CMD_UNLOCK1)
                     state_r <= FSR_SECURE_UNLOCK_FIRST;
               end
               FSR_SECURE_UNLOCK_FIRST:
               begin
                  if (rst_cmd)
                     state_r <= FSR_ARRAY_READ;
                  else if (at555 && cmd == FSR_CMD_SR_READ)
                  begin
                     ret_r <= FSR_SECURE_REGION_READ;
                     state_r <= FSR_SECURE_STATUS_READ;
                  end
                  else if (at2aa && cmd == FSR_CMD_UNLOCK2)
                     state_r <= FSR_SECURE_UNLOCK_SECOND;
                  else
                     state_r <= FSR_SECURE_PROGRAM_BUSY;
               end
               FSR_SECURE_UNLOCK_SECOND:
               begin
                  if (rst_cmd)
                     state_r <= FSR_SECURE_REGION_READ;
                  else if (at555 && cmd == FSR_CMD_WORD_PGM)
                     state_r <= FSR_SECURE_WORD_PROGRAM_ENTRY;
                  else if (cmd == FSR_CMD_BUF_LOAD)
                  begin
                     sect_r <= bus.sector;
                     state_r <= FSR_SECURE_BUFFER_LOAD;
                  end
                  else if (at555 && cmd == FSR_CMD_EXIT_ENTRY)
                     state_r <= FSR_SECURE_CMDSET_EXIT;
                  else
                     state_r <= FSR_SECURE_PROGRAM_BUSY;
               end
               FSR_SECURE_WORD_PROGRAM_ENTRY:
               begin
                  state_r <= FSR_SECURE_PROGRAM_BUSY;
               end
               FSR_SECURE_BUFFER_LOAD:
               begin
                  // Data written is the count minus one.
                  if (bus.wdata > 16'(FSR_MAX_WC - 9'h001) || bus.sector != sect_r)
                     state_r <= FSR_SECURE_PROGRAM_BUSY;
                  else
                  begin
                     wc_r <= bus.wdata[8:0] + 9'h001;
                     state_r <= FSR_SECURE_BUFFER_DATA;
                  end
               end
               FSR_SECURE_BUFFER_DATA:
               begin
                  if (bus.sector != sect_r || wc_r == 9'h000)
                     state_r <= FSR_SECURE_PROGRAM_BUSY;
                  else
                  begin
                     wc_r <= wc_r - 9'h001;
                     if (wc_r == 9'h001)
                        state_r <= FSR_SECURE_PROGRAM_BUSY;
                  end
               end
               FSR_SECURE_PROGRAM_BUSY:
               begin
                  if (!status_r[FSR_SR_READY])
                  begin
                     if (at555 && cmd == FSR_CMD_SR_READ)
                     begin
                        ret_r <= FSR_SECURE_PROGRAM_BUSY;
                        state_r <= FSR_SECURE_STATUS_READ;
                     end
                  end
                  else if (rst_cmd)
                     state_r <= FSR_ARRAY_READ;
                  else if (at555 && cmd == FSR_CMD_SR_CLEAR)
                     state_r <= FSR_SECURE_REGION_READ;
                  else if (at555 && cmd == FSR_CMD_SR_READ)
                  begin
                     ret_r <= FSR_SECURE_PROGRAM_BUSY;
                     state_r <= FSR_SECURE_STATUS_READ;
                  end
                  else if (at555 && cmd == FSR_CMD_UNLOCK1)
                     state_r <= FSR_SECURE_UNLOCK_FIRST;
               end
               FSR_SECURE_CMDSET_EXIT:
               begin
                  if (cmd == FSR_CMD_EXIT)
                     state_r <= FSR_ARRAY_READ;
                  else if (at555 && cmd == FSR_CMD_SR_READ)
                  begin
                     ret_r <= FSR_SECURE_REGION_READ;
                     state_r <= FSR_SECURE_STATUS_READ;
                  end
               end
               default:
               begin
                  // Writes during a status read are ignored.
                  state_r <= state_r;
               end
            endcase
         end
         else if (state_r == FSR_ARRAY_READ && enter_query_i)
            state_r <= FSR_QUERY;
         else if (state_r == FSR_ARRAY_READ && enter_secure_i)
            state_r <= FSR_SECURE_REGION_READ;
      end
   end
   // ****************************************
   // Program timer and status register.
   // ****************************************
   // A fixed model time stands in for the array; abort sets bit 3 and skips programming.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         status_r <= FSR_SR_RESET;
         busy_r <= 8'h00;
      end
      else if (ce_i)
      begin
         if (bus.we && state_r != FSR_SECURE_PROGRAM_BUSY
             && state_r != FSR_SECURE_STATUS_READ
             && state_r != FSR_QUERY_STATUS_READ
             && (state_r == FSR_SECURE_WORD_PROGRAM_ENTRY
                 || (state_r == FSR_SECURE_BUFFER_DATA && wc_r == 9'h001
                     && bus.sector == sect_r)))
         begin
            status_r[FSR_SR_READY] <= 1'b0; // Program starts.
            busy_r <= FSR_PGM_CYC;
         end
         else if (bus.we && ((state_r == FSR_SECURE_BUFFER_LOAD
                  && (bus.wdata > 16'(FSR_MAX_WC - 9'h001) || bus.sector != sect_r))
                  || (state_r == FSR_SECURE_BUFFER_DATA && bus.sector != sect_r)))
            status_r[FSR_SR_ABORT] <= 1'b1;
         else if (busy_r != 8'h00)
         begin
            busy_r <= busy_r - 8'h01;
            if (busy_r == 8'h01)
               status_r[FSR_SR_READY] <= 1'b1;
         end
         else if (bus.we && at555 && cmd == FSR_CMD_SR_CLEAR && status_r[FSR_SR_READY]
                  && (state_r == FSR_QUERY || state_r == FSR_SECURE_PROGRAM_BUSY
                      || state_r == FSR_SECURE_REGION_READ))
            status_r <= FSR_SR_RESET;
      end
   end
   // ****************************************
   // Program request and read answer.
   // ****************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pgm_start_o <= 1'b0;
         pgm_addr_o <= '0;
         pgm_data_o <= '0;
         bus.rvalid <= 1'b0;
         bus.rdata <= '0;
      end
      else if (ce_i)
      begin
         pgm_start_o <= bus.we && (state_r == FSR_SECURE_WORD_PROGRAM_ENTRY
                        || (state_r == FSR_SECURE_BUFFER_DATA && bus.sector == sect_r));
         if (bus.we)
         begin
            pgm_addr_o <= bus.addr;
            pgm_data_o <= bus.wdata;
         end
         bus.rvalid <= bus.re;
         case (state_r)
            FSR_QUERY: bus.rdata <= query_data_i;
            FSR_SECURE_REGION_READ: bus.rdata <= secure_data_i;
            FSR_SECURE_STATUS_READ,
            FSR_QUERY_STATUS_READ,
            FSR_SECURE_PROGRAM_BUSY: bus.rdata <= {8'h00, status_r};
            default: bus.rdata <= array_data_i;
         endcase
      end
   end
endmodule

// file: rtl/fsr_host.sv
// Host end: turns one user request into a single command bus cycle.
// Assumes the user holds each request one cycle and waits for done_o.
`timescale 1ns/1ps
module fsr_host
   import fsr_pkg::*;
(
   input wire logic clk_i, // Clock.
   input wire logic rst_i, // Synchronous reset, high.
   input wire logic ce_i, // Clock enable; low freezes state.
   fsr_if.host bus, // Command bus.
   input wire logic wr_i, // Write request, pulse.
   input wire logic rd_i, // Read request, pulse.
   input wire logic [FSR_AW-1:0] addr_i, // Address.
   input wire logic [FSR_SW-1:0] sector_i, // Sector.
   input wire logic [FSR_DW-1:0] wdata_i, // Write data.
   output logic [FSR_DW-1:0] rdata_o, // Read data.
   output logic done_o // Request finished, pulse.
);
   // ****************************************
   // Bus cycle generator.
   // ****************************************
   // Host issues unlock, 55h at 2AAh and other sequences as its user orders.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bus.we <= 1'b0;
         bus.re <= 1'b0;
         bus.addr <= '0;
         bus.sector <= '0;
         bus.wdata <= '0;
      end
      else if (ce_i)
      begin
         bus.we <= wr_i;
         bus.re <= rd_i && !wr_i;
         if (wr_i || rd_i)
         begin
            bus.addr <= addr_i;
            bus.sector <= sector_i;
            bus.wdata <= wdata_i;
         end
      end
   end
   // Answer capture; writes finish after one cycle, reads on rvalid.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_o <= '0;
         done_o <= 1'b0;
      end
      else if (ce_i)
      begin
         done_o <= bus.we || bus.rvalid;
         if (bus.rvalid)
            rdata_o <= bus.rdata;
      end
   end
endmodule

// file: tb/fsr_sva.sv
// Checker for the secure region command path: bus strobes and state steps.
// Assumes it sits beside the bus interface and also sees the device state code.
`timescale 1ns/1ps
module fsr_sva
   import fsr_pkg::*;
(
   input wire logic clk_i, // Clock.
   input wire logic rst_i, // Synchronous reset, high.
   input wire logic we, // Write strobe.
   input wire logic re, // Read strobe.
   input wire logic [FSR_AW-1:0] addr, // Command address.
   input wire logic [FSR_DW-1:0] wdata, // Write data.
   input wire logic rvalid, // Read answer.
   input wire logic [3:0] state_o // Device state code.
);
   // ****************************************
   // Helpers.
   // ****************************************
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] cd; // Command byte of the write.
   logic at_cmd; // Write at the command address.
   assign cd = wdata[7:0];
   assign at_cmd = we && addr == FSR_ADDR_UNLOCK1;
   // ****************************************
   // Assertions.
   // ****************************************
   // Only one strobe at a time, since a write request wins over a read.
   strobe_onehot_a: assert property (we |-> !re) else $error("write and read strobe together");
   // The read answer comes exactly one cycle after the strobe.
   read_answer_a: assert property (re |=> rvalid) else $error("read answer missing");
   query_exit_a: assert property (state_o == FSR_QUERY && we && cd == FSR_CMD_RESET
      |=> state_o == FSR_ARRAY_READ) else $error("query exit missed");
   query_status_a: assert property (state_o == FSR_QUERY && at_cmd
      && cd == FSR_CMD_SR_READ |=> state_o == FSR_QUERY_STATUS_READ) else $error("no status");
   // The one-shot status read gives way after a single read.
   status_return_a: assert property (state_o == FSR_QUERY_STATUS_READ && re
      |-> ##[1:2] state_o == FSR_QUERY) else $error("status read did not return");
   unlock_first_a: assert property (state_o == FSR_SECURE_REGION_READ && at_cmd
      && cd == FSR_CMD_UNLOCK1 |=> state_o == FSR_SECURE_UNLOCK_FIRST) else $error("unlock1");
   unlock_second_a: assert property (state_o == FSR_SECURE_UNLOCK_FIRST && we
      && addr == FSR_ADDR_UNLOCK2 && cd == FSR_CMD_UNLOCK2
      |=> state_o == FSR_SECURE_UNLOCK_SECOND) else $error("unlock2 missed");
   // A stray write in the first unlock stage must not be silently dropped.
   bad_unlock_a: assert property (state_o == FSR_SECURE_UNLOCK_FIRST && we
      && !(addr == FSR_ADDR_UNLOCK2 && cd == FSR_CMD_UNLOCK2) && cd != FSR_CMD_RESET
      && !(at_cmd && cd == FSR_CMD_SR_READ) |=> state_o == FSR_SECURE_PROGRAM_BUSY)
      else $error("bad unlock not aborted");
   cmdset_exit_a: assert property (state_o == FSR_SECURE_CMDSET_EXIT && we
      && cd == FSR_CMD_EXIT |=> state_o == FSR_ARRAY_READ) else $error("exit missed");
   secure_status_a: assert property (state_o == FSR_SECURE_STATUS_READ && re
      |-> ##[1:2] state_o != FSR_SECURE_STATUS_READ) else $error("status state stuck");
endmodule

// file: tb/test_flash_cfi_secure_region_cmd_fsm.sv
// Testbench: host end and device end joined by the bus, driven through the host.
// Assumes a 25 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module test_flash_cfi_secure_region_cmd_fsm;
   import fsr_pkg::*;
   // ****************************************
   // Signals.
   // ****************************************
   logic clk_i, rst_i, ce_i, enter_query_i, enter_secure_i, wr_i, rd_i, done_o, pgm_start_o;
   logic [FSR_AW-1:0] addr_i, pgm_addr_o; // Request and program addresses.
   logic [FSR_SW-1:0] sector_i; // Request sector.
   logic [FSR_DW-1:0] wdata_i, rdata_o, pgm_data_o; // Data paths.
   logic [3:0] state_o; // Device state.
   int n_errors, samples_checked, cycles, n_pgm; // Counters.
   fsr_if bus (.clk_i(clk_i));
   fsr_host i_fsr_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus(bus), .wr_i(wr_i),
      .rd_i(rd_i), .addr_i(addr_i), .sector_i(sector_i), .wdata_i(wdata_i),
      .rdata_o(rdata_o), .done_o(done_o));
   // Read sources are fixed, distinct words so a wrong mux choice shows.
   fsr_device i_fsr_device (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus(bus),
      .enter_query_i(enter_query_i), .enter_secure_i(enter_secure_i),
      .array_data_i(16'ha1a1), .query_data_i(16'hc0c0), .secure_data_i(16'h5e5e),
      .pgm_start_o(pgm_start_o), .pgm_addr_o(pgm_addr_o), .pgm_data_o(pgm_data_o),
      .state_o(state_o));
   fsr_sva i_fsr_sva (.clk_i(clk_i), .rst_i(rst_i), .we(bus.we), .re(bus.re),
      .addr(bus.addr), .wdata(bus.wdata), .rvalid(bus.rvalid), .state_o(state_o));
   initial
   begin
      clk_i = 0;
      forever #20 clk_i = ~clk_i;
   end
   // Cycle ceiling and program start count; the ceiling is several times the run.
   always @(posedge clk_i)
   begin
      cycles++;
      if (pgm_start_o === 1'b1)
         n_pgm++;
      if (cycles == 8000)
      begin
         n_errors++;
         test_done();
      end
   end
   // ****************************************
   // Shared tasks.
   // ****************************************
   task automatic test_done();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic st(input fsr_state_type e);
      chk("state", 16'(e), 16'(state_o));
   endtask
   // One request, then a bounded wait for done; wr_i wins, so rd_i is only set alone.
   task automatic req(input logic w, input logic [11:0] a, input logic [7:0] s,
      input logic [15:0] d);
      int k;
      @(negedge clk_i);
      wr_i = w;
      rd_i = !w;
      addr_i = a;
      sector_i = s;
      wdata_i = d;
      @(negedge clk_i);
      wr_i = 0;
      rd_i = 0;
      k = 0;
      while (done_o !== 1'b1 && k < 8)
      begin
         @(negedge clk_i);
         k++;
      end
      if (k == 8)
         chk("done", 16'h1, 16'h0);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] s, input logic [15:0] d);
      req(1, a, s, d);
   endtask
   task automatic rd(input logic [15:0] exp);
      req(0, 12'h0, 8'h0, 16'h0);
      chk("read", exp, rdata_o);
   endtask
   task automatic enter(input logic q);
      @(negedge clk_i);
      enter_query_i = q;
      enter_secure_i = !q;
      @(negedge clk_i);
      enter_query_i = 0;
      enter_secure_i = 0;
   endtask
   task automatic unlock();
      wr(FSR_ADDR_UNLOCK1, 8'h0, 16'h00aa);
      st(FSR_SECURE_UNLOCK_FIRST);
      wr(FSR_ADDR_UNLOCK2, 8'h0, 16'h0055);
      st(FSR_SECURE_UNLOCK_SECOND);
   endtask
   // ****************************************
   // Scenarios.
   // ****************************************
   task automatic t_query();
      enter(1);
      rd(16'hc0c0);
      wr(FSR_ADDR_UNLOCK1, 8'h0, 16'h0070);
      st(FSR_QUERY_STATUS_READ);
      rd(16'h0080);
      rd(16'hc0c0);
      wr(FSR_ADDR_UNLOCK1, 8'h0, 16'h0071);
      st(FSR_QUERY);
      wr(12'h123, 8'h0, 16'h00f0);
      rd(16'ha1a1);
   endtask
   task automatic t_secure();
      enter(0);
      rd(16'h5e5e);
      wr(FSR_ADDR_UNLOCK1, 8'h0, 16'h0070);
      rd(16'h0080);
      st(FSR_SECURE_REGION_READ);
      unlock();
      wr(FSR_ADDR_UNLOCK1, 8'h0, 16'h0090);
      st(FSR_SECURE_CMDSET_EXIT);
      wr(12'h0, 8'h0, 16'h0000);
      st(FSR_ARRAY_READ);
      enter(0);
      unlock();
      wr(12'h0, 8'h0, 16'h00f0);
      st(FSR_SECURE_REGION_READ);
      wr(12'h0, 8'h0, 16'h00f0);
      st(FSR_ARRAY_READ);
   endtask
   // Stray writes in both unlock stages, each cleared by a status clear or a reset.
   task automatic t_bad();
      enter(0);
      wr(FSR_ADDR_UNLOCK1, 8'h0, 16'h00aa);
      wr(FSR_ADDR_UNLOCK2, 8'h0, 16'h0012);
      st(FSR_SECURE_PROGRAM_BUSY);
      wr(FSR_ADDR_UNLOCK1, 8'h0, 16'h0071);
      st(FSR_SECURE_REGION_READ);
      unlock();
      wr(12'h123, 8'h0, 16'h00a0);
      st(FSR_SECURE_PROGRAM_BUSY);
      wr(12'h0, 8'h0, 16'h00f0);
      st(FSR_ARRAY_READ);
   endtask
   task automatic t_word();
      int n0;
      n0 = n_pgm;
      enter(0);
      unlock();
      wr(FSR_ADDR_UNLOCK1, 8'h0, 16'h00a0);
      st(FSR_SECURE_WORD_PROGRAM_ENTRY);
      wr(12'h010, 8'h0, 16'h1234);
      chk("pgm addr", 16'h0010, 16'(pgm_addr_o));
      chk("pgm data", 16'h1234, pgm_data_o);
      wr(12'h0, 8'h0, 16'h00f0);
      st(FSR_SECURE_PROGRAM_BUSY);
      // The start pulse is counted one edge after it rises, so look only now.
      chk("pgm count", 16'(n0 + 1), 16'(n_pgm));
      wr(FSR_ADDR_UNLOCK1, 8'h0, 16'h0070);
      st(FSR_SECURE_STATUS_READ);
      // Still busy here, so the status word shows ready clear.
      rd(16'h0000);
      st(FSR_SECURE_PROGRAM_BUSY);
      repeat (12) @(negedge clk_i);
      rd(16'h0080);
      wr(12'h0, 8'h0, 16'h00f0);
      st(FSR_ARRAY_READ);
   endtask
   // Largest legal count, then a count one over and a sector change, both aborting.
   task automatic t_buf();
      int n0;
      n0 = n_pgm;
      enter(0);
      unlock();
      wr(12'h0, 8'h03, 16'h0025);
      st(FSR_SECURE_BUFFER_LOAD);
      wr(12'h0, 8'h03, 16'h00ff);
      st(FSR_SECURE_BUFFER_DATA);
      for (int i = 0; i < 256; i++)
         wr(12'(i), 8'h03, 16'(i));
      // Every buffered word is handed on with its own start pulse; wait for the last count.
      @(negedge clk_i);
      chk("pgm count", 16'(n0 + 256), 16'(n_pgm));
      repeat (12) @(negedge clk_i);
      wr(FSR_ADDR_UNLOCK1, 8'h0, 16'h0071);
      st(FSR_SECURE_REGION_READ);
      unlock();
      wr(12'h0, 8'h03, 16'h0025);
      wr(12'h0, 8'h03, 16'h0100);
      rd(16'h0088);
      wr(FSR_ADDR_UNLOCK1, 8'h0, 16'h0071);
      unlock();
      wr(12'h0, 8'h03, 16'h0025);
      wr(12'h0, 8'h04, 16'h0001);
      rd(16'h0088);
      chk("pgm count", 16'(n0 + 256), 16'(n_pgm));
      wr(12'h0, 8'h0, 16'h00f0);
      st(FSR_ARRAY_READ);
   endtask
   // ****************************************
   // Main sequence.
   // ****************************************
   initial
   begin
      rst_i = 1;
      ce_i = 1;
      enter_query_i = 0;
      enter_secure_i = 0;
      wr_i = 0;
      rd_i = 0;
      addr_i = 0;
      sector_i = 0;
      wdata_i = 0;
      repeat (3) @(negedge clk_i);
      rst_i = 0;
      st(FSR_ARRAY_READ);
      t_query();
      t_secure();
      t_bad();
      t_word();
      t_buf();
      test_done();
   end
endmodule
